// ### rtl/latch_timer_defines.vh
// Purpose: constants for the latch and delay timer set
// Assumes: 10 MHz clock, millisecond tick derived from it
// Notes: included by both design files
`ifndef LATCH_TIMER_DEFINES_VH
`define LATCH_TIMER_DEFINES_VH

// ****************************************
// widths and timing
// ****************************************
`define TIME_W 32
`define CLK_HZ 10000000
`define TICK_PERIOD_MS 1
// cycles per millisecond tick, derived from clock rate
`define TICK_CYCLES ((`CLK_HZ / 1000) * `TICK_PERIOD_MS)
`define TICK_CNT_W 14
`define TICK_CNT_ZERO 14'h0000
// last prescaler count before the tick, TICK_CYCLES - 1 at 10 MHz
`define TICK_LAST 14'h270f

// ****************************************
// timer modes
// ****************************************
`define MODE_OFF_DELAY 2'h0
`define MODE_ON_DELAY 2'h1
`define MODE_PULSE 2'h2

`define TIME_ZERO 32'h0000_0000
`define TIME_ONE 32'h0000_0001

`endif

// ### rtl/ms_timer_core.v
// Purpose: one millisecond timer, off-delay, on-delay or pulse
// Assumes: tick_i is a one-cycle pulse once per millisecond
// Notes: outputs registered; enable low clears all state
`timescale 1ns/1ps
`include "latch_timer_defines.vh"

module ms_timer_core #(
   parameter [1:0] MODE = `MODE_ON_DELAY
) (
   // clock and reset
   input wire mclk_i,
   input wire rstn_i,
   // control
   input wire enable_i,
   input wire tick_i,
   input wire trigger_i,
   input wire [`TIME_W-1:0] preset_ms_i,
   // results
   output reg q_o,
   output reg [`TIME_W-1:0] elapsed_ms_o
);

   reg trig_d_reg;
   reg running_reg;
   reg running_next;
   reg q_next;
   reg [`TIME_W-1:0] elapsed_next;
   wire rise = trigger_i & ~trig_d_reg;
   wire fall = ~trigger_i & trig_d_reg;
   // preset read live each cycle, so a changed preset takes effect at once
   wire done = (elapsed_ms_o >= preset_ms_i);

   // a zero preset asks for no interval at all
   function preset_nonzero;
      input [`TIME_W-1:0] preset;
      begin
         preset_nonzero = (preset != `TIME_ZERO);
      end
   endfunction

   // one more whole millisecond; wraps only after about 49 days of counting
   function [`TIME_W-1:0] ms_step;
      input [`TIME_W-1:0] ms;
      begin
         ms_step = ms + `TIME_ONE;
      end
   endfunction

   // ****************************************
   // next-state per mode
   // ****************************************
   always @* begin
      running_next = running_reg;
      q_next = q_o;
      elapsed_next = elapsed_ms_o;
      case (MODE)
         `MODE_OFF_DELAY: begin
            if (trigger_i) begin
               running_next = 1'b0;
               q_next = 1'b1;
               elapsed_next = `TIME_ZERO;
            end else if (fall) begin
               running_next = preset_nonzero(preset_ms_i);
               q_next = preset_nonzero(preset_ms_i);
               elapsed_next = `TIME_ZERO;
            end else if (running_reg) begin
               if (done) begin
                  running_next = 1'b0;
                  q_next = 1'b0;
                  elapsed_next = `TIME_ZERO;
               end else if (tick_i) begin
                  elapsed_next = ms_step(elapsed_ms_o);
               end
            end
         end
         `MODE_ON_DELAY: begin
            if (!trigger_i) begin
               running_next = 1'b0;
               q_next = 1'b0;
               elapsed_next = `TIME_ZERO;
            end else if (rise) begin
               running_next = 1'b1;
               elapsed_next = `TIME_ZERO;
            end else if (running_reg) begin
               if (done) begin
                  q_next = 1'b1;
                  elapsed_next = preset_ms_i;
               end else if (tick_i) begin
                  elapsed_next = ms_step(elapsed_ms_o);
               end
            end
         end
         default: begin
            // pulse: trigger looked at only while idle
            if (running_reg) begin
               if (done) begin
                  running_next = 1'b0;
                  q_next = 1'b0;
                  elapsed_next = `TIME_ZERO;
               end else if (tick_i) begin
                  elapsed_next = ms_step(elapsed_ms_o);
               end
            end else if (rise && preset_nonzero(preset_ms_i)) begin
               running_next = 1'b1;
               q_next = 1'b1;
               elapsed_next = `TIME_ZERO;
            end
         end
      endcase
   end

   // ****************************************
   // state registers, cleared while disabled
   // ****************************************
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trig_d_reg <= 1'b0;
         running_reg <= 1'b0;
         q_o <= 1'b0;
         elapsed_ms_o <= `TIME_ZERO;
      end else if (!enable_i) begin
         // holding trig_d low lets a high trigger count as rising on enable
         trig_d_reg <= 1'b0;
         running_reg <= 1'b0;
         q_o <= 1'b0;
         elapsed_ms_o <= `TIME_ZERO;
      end else begin
         trig_d_reg <= trigger_i;
         running_reg <= running_next;
         q_o <= q_next;
         elapsed_ms_o <= elapsed_next;
      end
   end

endmodule

// ### rtl/latch_and_delay_timer_set.v
// Purpose: latches and millisecond timers, enabled and reduced forms
// Assumes: inputs synchronous to mclk_i; presets are live inputs
// Notes: one shared millisecond tick; elapsed counts in whole ms
`timescale 1ns/1ps
`include "latch_timer_defines.vh"

module latch_and_delay_timer_set (
   // clock and reset
   input wire mclk_i,
   input wire rstn_i,
   // enabled reset-dominant latch
   input wire rdl_enable_i,
   input wire rdl_wipe_i,
   input wire rdl_latch_on_i,
   output reg rdl_enable_out_o,
   output reg rdl_q_o,
   // reduced reset-dominant latch
   input wire rrd_wipe_i,
   input wire rrd_latch_on_i,
   output reg rrd_q_o,
   // enabled set-dominant latch
   input wire sdl_enable_i,
   input wire sdl_wipe_i,
   input wire sdl_latch_on_i,
   output reg sdl_enable_out_o,
   output reg sdl_q_o,
   // reduced set-dominant latch
   input wire rsd_wipe_i,
   input wire rsd_latch_on_i,
   output reg rsd_q_o,
   // enabled off-delay timer
   input wire ofd_enable_i,
   input wire ofd_trigger_i,
   input wire [`TIME_W-1:0] ofd_preset_ms_i,
   output reg ofd_enable_out_o,
   output wire ofd_q_o,
   output wire [`TIME_W-1:0] ofd_elapsed_ms_o,
   // reduced off-delay timer
   input wire rof_trigger_i,
   input wire [`TIME_W-1:0] rof_preset_ms_i,
   output wire rof_q_o,
   output wire [`TIME_W-1:0] rof_elapsed_ms_o,
   // enabled on-delay timer
   input wire ond_enable_i,
   input wire ond_trigger_i,
   input wire [`TIME_W-1:0] ond_preset_ms_i,
   output reg ond_enable_out_o,
   output wire ond_q_o,
   output wire [`TIME_W-1:0] ond_elapsed_ms_o,
   // reduced on-delay timer
   input wire ron_trigger_i,
   input wire [`TIME_W-1:0] ron_preset_ms_i,
   output wire ron_q_o,
   output wire [`TIME_W-1:0] ron_elapsed_ms_o,
   // enabled pulse timer
   input wire pls_enable_i,
   input wire pls_trigger_i,
   input wire [`TIME_W-1:0] pls_preset_ms_i,
   output reg pls_enable_out_o,
   output wire pls_q_o,
   output wire [`TIME_W-1:0] pls_elapsed_ms_o,
   // reduced pulse timer
   input wire rpl_trigger_i,
   input wire [`TIME_W-1:0] rpl_preset_ms_i,
   output wire rpl_q_o,
   output wire [`TIME_W-1:0] rpl_elapsed_ms_o
);

   // ****************************************
   // overview
   // ****************************************
   // every block samples its inputs on each rising clock edge and
   // answers one cycle later through a register, so the outputs
   // never glitch while the control logic around them settles.
   // the latches keep their state in their own output flop; each
   // timer owns a counter in ms_timer_core and all of them share
   // one millisecond strobe.
   // timing is in whole shared ticks: an interval may run short by
   // up to one tick less one cycle, never long by more than a few
   // cycles; a finer tick would cut that error at the cost of wider
   // counters.
   // disabling a block clears its state; on re-enable a trigger that
   // is already high counts as a fresh rising edge.
   // reduced blocks are the same logic with the enable tied high.

   // ****************************************
   // latch functions
   // ****************************************
   // reset wins when both inputs are true
   function reset_dominant_latch;
      input q;
      input wipe;
      input latch_on;
      begin
         reset_dominant_latch = ~wipe & (latch_on | q);
      end
   endfunction

   // set wins when both inputs are true
   function set_dominant_latch;
      input q;
      input wipe;
      input latch_on;
      begin
         set_dominant_latch = latch_on | (~wipe & q);
      end
   endfunction

   // ****************************************
   // millisecond tick
   // ****************************************
   reg [`TICK_CNT_W-1:0] tick_cnt_reg;
   reg tick_reg;
   // single shared prescaler: all timers step on the same ms boundary,
   // so the first ms of an interval may be short by up to one tick
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_cnt_reg <= `TICK_CNT_ZERO;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg == `TICK_LAST) begin
         tick_cnt_reg <= `TICK_CNT_ZERO;
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + {{(`TICK_CNT_W-1){1'b0}}, 1'b1};
         tick_reg <= 1'b0;
      end
   end

   // ****************************************
   // latches
   // ****************************************
   // enabled reset-dominant latch; enable low drops q at the next edge
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdl_q_o <= 1'b0;
      end else begin
         rdl_q_o <= rdl_enable_i &
            reset_dominant_latch(rdl_q_o, rdl_wipe_i, rdl_latch_on_i);
      end
   end

   // reduced reset-dominant latch, the same logic always enabled
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rrd_q_o <= 1'b0;
      end else begin
         rrd_q_o <= reset_dominant_latch(rrd_q_o, rrd_wipe_i,
            rrd_latch_on_i);
      end
   end

   // enabled set-dominant latch; enable wins over a held set
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sdl_q_o <= 1'b0;
      end else begin
         sdl_q_o <= sdl_enable_i &
            set_dominant_latch(sdl_q_o, sdl_wipe_i, sdl_latch_on_i);
      end
   end

   // reduced set-dominant latch, the same logic always enabled
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rsd_q_o <= 1'b0;
      end else begin
         rsd_q_o <= set_dominant_latch(rsd_q_o, rsd_wipe_i,
            rsd_latch_on_i);
      end
   end

   // ****************************************
   // enable followers
   // ****************************************
   // registered copies: one cycle of lag, but no path straight through
   always @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdl_enable_out_o <= 1'b0;
         sdl_enable_out_o <= 1'b0;
         ofd_enable_out_o <= 1'b0;
         ond_enable_out_o <= 1'b0;
         pls_enable_out_o <= 1'b0;
      end else begin
         rdl_enable_out_o <= rdl_enable_i;
         sdl_enable_out_o <= sdl_enable_i;
         ofd_enable_out_o <= ofd_enable_i;
         ond_enable_out_o <= ond_enable_i;
         pls_enable_out_o <= pls_enable_i;
      end
   end

   // ****************************************
   // timers; reduced forms tied permanently enabled
   // ****************************************
   // enabled off-delay timer
   ms_timer_core #(
      .MODE(`MODE_OFF_DELAY)
   ) u_off_delay_timer (
      // clock and reset
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      // control
      .enable_i(ofd_enable_i),
      .tick_i(tick_reg),
      .trigger_i(ofd_trigger_i),
      .preset_ms_i(ofd_preset_ms_i),
      // results
      .q_o(ofd_q_o),
      .elapsed_ms_o(ofd_elapsed_ms_o)
   );

   // reduced off-delay timer
   ms_timer_core #(
      .MODE(`MODE_OFF_DELAY)
   ) u_reduced_off_delay (
      // clock and reset
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      // control
      .enable_i(1'b1),
      .tick_i(tick_reg),
      .trigger_i(rof_trigger_i),
      .preset_ms_i(rof_preset_ms_i),
      // results
      .q_o(rof_q_o),
      .elapsed_ms_o(rof_elapsed_ms_o)
   );

   // enabled on-delay timer
   ms_timer_core #(
      .MODE(`MODE_ON_DELAY)
   ) u_on_delay_timer (
      // clock and reset
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      // control
      .enable_i(ond_enable_i),
      .tick_i(tick_reg),
      .trigger_i(ond_trigger_i),
      .preset_ms_i(ond_preset_ms_i),
      // results
      .q_o(ond_q_o),
      .elapsed_ms_o(ond_elapsed_ms_o)
   );

   // reduced on-delay timer
   ms_timer_core #(
      .MODE(`MODE_ON_DELAY)
   ) u_reduced_on_delay (
      // clock and reset
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      // control
      .enable_i(1'b1),
      .tick_i(tick_reg),
      .trigger_i(ron_trigger_i),
      .preset_ms_i(ron_preset_ms_i),
      // results
      .q_o(ron_q_o),
      .elapsed_ms_o(ron_elapsed_ms_o)
   );

   // enabled pulse timer
   ms_timer_core #(
      .MODE(`MODE_PULSE)
   ) u_pulse_timer (
      // clock and reset
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      // control
      .enable_i(pls_enable_i),
      .tick_i(tick_reg),
      .trigger_i(pls_trigger_i),
      .preset_ms_i(pls_preset_ms_i),
      // results
      .q_o(pls_q_o),
      .elapsed_ms_o(pls_elapsed_ms_o)
   );

   // reduced pulse timer
   ms_timer_core #(
      .MODE(`MODE_PULSE)
   ) u_reduced_pulse (
      // clock and reset
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      // control
      .enable_i(1'b1),
      .tick_i(tick_reg),
      .trigger_i(rpl_trigger_i),
      .preset_ms_i(rpl_preset_ms_i),
      // results
      .q_o(rpl_q_o),
      .elapsed_ms_o(rpl_elapsed_ms_o)
   );

endmodule

// ### verification/latch_timer_asserts.sv
// Purpose: port checks of the latch and timer set
// Assumes: inputs held low during reset
// Notes: ports grouped several a line to keep the file short
`timescale 1ns/1ps
`include "latch_timer_defines.vh"
module latch_timer_asserts (
   // clock and reset
   input wire mclk_i, rstn_i,
   // latches
   input wire rdl_enable_i, rdl_wipe_i, rdl_q_o, rdl_enable_out_o,
   input wire sdl_enable_i, sdl_latch_on_i, sdl_q_o,
   // timers
   input wire ofd_enable_i, ofd_trigger_i, ofd_q_o,
   input wire [`TIME_W-1:0] ofd_preset_ms_i, ofd_elapsed_ms_o,
   input wire ond_enable_i, ond_trigger_i, ond_q_o,
   input wire pls_enable_i, pls_q_o,
   input wire [`TIME_W-1:0] pls_preset_ms_i, pls_elapsed_ms_o
);
   // ****
   // checks
   // ****
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   // interval over: off-delay must drop next cycle
   sequence ofd_spent;
      ofd_enable_i && !ofd_trigger_i && ofd_q_o &&
         ofd_elapsed_ms_o >= ofd_preset_ms_i;
   endsequence
   // pulse still short of its preset
   sequence pls_busy;
      pls_enable_i && pls_q_o && pls_elapsed_ms_o < pls_preset_ms_i;
   endsequence
   chk_rdl_wipe_wins: assert property (
      rdl_enable_i && rdl_wipe_i |=> !rdl_q_o) else $error("rdl set");
   chk_sdl_set_wins: assert property (
      sdl_enable_i && sdl_latch_on_i |=> sdl_q_o) else $error("sdl clr");
   chk_pls_disabled: assert property (
      !pls_enable_i |=> !pls_q_o && pls_elapsed_ms_o == 0)
      else $error("pulse not cleared");
   // first edge after reset sees a stale past, so skip it
   chk_enable_follows: assert property (
      $past(rstn_i) |-> rdl_enable_out_o == $past(rdl_enable_i))
      else $error("enable out lag");
   chk_ofd_holds: assert property (
      ofd_enable_i && ofd_trigger_i |=> ofd_q_o) else $error("ofd low");
   chk_ofd_expires: assert property (
      ofd_spent |=> !ofd_q_o && ofd_elapsed_ms_o == 0)
      else $error("ofd late");
   chk_ond_drops: assert property (
      ond_enable_i && !ond_trigger_i |=> !ond_q_o) else $error("ond hi");
   chk_pls_ignores: assert property (
      pls_busy |=> pls_q_o) else $error("pulse cut short");
endmodule
bind latch_and_delay_timer_set latch_timer_asserts latch_timer_asserts_i (
   .mclk_i, .rstn_i, .rdl_enable_i, .rdl_wipe_i, .rdl_q_o,
   .rdl_enable_out_o, .sdl_enable_i, .sdl_latch_on_i, .sdl_q_o,
   .ofd_enable_i, .ofd_trigger_i, .ofd_q_o, .ofd_preset_ms_i,
   .ofd_elapsed_ms_o, .ond_enable_i, .ond_trigger_i, .ond_q_o,
   .pls_enable_i, .pls_q_o, .pls_preset_ms_i, .pls_elapsed_ms_o);

// ### verification/preset_source.sv
// Purpose: control logic feeding live presets
// Assumes: level set by the bench
// Notes: long preset is one ms above short
`timescale 1ns/1ps
`include "latch_timer_defines.vh"
module preset_source (
   // clock
   input wire mclk_i,
   // live level
   input wire [`TIME_W-1:0] level_i,
   // presets
   output reg [`TIME_W-1:0] short_o,
   output reg [`TIME_W-1:0] long_o
);
   // registered, as another block's output would be
   always @(posedge mclk_i) begin
      short_o <= level_i;
      long_o <= level_i + 32'h1;
   end
endmodule

// ### verification/tb.sv
// Purpose: self-checking bench for the latch and timer set
// Assumes: one tick per ms, presets 1 and 2 ms
// Notes: reduced blocks share stimulus with enabled ones
`timescale 1ns/1ps
`include "latch_timer_defines.vh"
module tb;
   // ****
   // signals
   // ****
   logic mclk_i = 1'h0, rstn_i = 1'h0, l_en = 1'h0, l_w = 1'h0;
   logic l_on = 1'h0, f_en = 1'h0, f_tr = 1'h0, n_en = 1'h0;
   logic n_tr = 1'h0, p_en = 1'h0, p_tr = 1'h0;
   logic [`TIME_W-1:0] lvl = 32'h0;
   wire [`TIME_W-1:0] ps, pl, f_el, rf_el, n_el, rn_el, p_el, rp_el;
   wire rdl_eo, rdl_q, rrd_q, sdl_eo, sdl_q, rsd_q, f_eo, f_q, rf_q;
   wire n_eo, n_q, rn_q, p_eo, p_q, rp_q;
   int err_total = 0;
   int n_compared = 0;
   localparam int MS = `TICK_CYCLES;
   always #50 mclk_i = ~mclk_i;
   preset_source preset_source_i (.mclk_i(mclk_i), .level_i(lvl),
      .short_o(ps), .long_o(pl));
   latch_and_delay_timer_set latch_and_delay_timer_set_i (
      .mclk_i(mclk_i), .rstn_i(rstn_i), .rdl_enable_i(l_en),
      .rdl_wipe_i(l_w), .rdl_latch_on_i(l_on), .rdl_enable_out_o(rdl_eo),
      .rdl_q_o(rdl_q), .rrd_wipe_i(l_w), .rrd_latch_on_i(l_on),
      .rrd_q_o(rrd_q), .sdl_enable_i(l_en), .sdl_wipe_i(l_w),
      .sdl_latch_on_i(l_on), .sdl_enable_out_o(sdl_eo), .sdl_q_o(sdl_q),
      .rsd_wipe_i(l_w), .rsd_latch_on_i(l_on), .rsd_q_o(rsd_q),
      .ofd_enable_i(f_en), .ofd_trigger_i(f_tr), .ofd_preset_ms_i(pl),
      .ofd_enable_out_o(f_eo), .ofd_q_o(f_q), .ofd_elapsed_ms_o(f_el),
      .rof_trigger_i(f_tr), .rof_preset_ms_i(ps), .rof_q_o(rf_q),
      .rof_elapsed_ms_o(rf_el), .ond_enable_i(n_en), .ond_trigger_i(n_tr),
      .ond_preset_ms_i(pl), .ond_enable_out_o(n_eo), .ond_q_o(n_q),
      .ond_elapsed_ms_o(n_el), .ron_trigger_i(n_tr), .ron_preset_ms_i(ps),
      .ron_q_o(rn_q), .ron_elapsed_ms_o(rn_el), .pls_enable_i(p_en),
      .pls_trigger_i(p_tr), .pls_preset_ms_i(pl), .pls_enable_out_o(p_eo),
      .pls_q_o(p_q), .pls_elapsed_ms_o(p_el), .rpl_trigger_i(p_tr),
      .rpl_preset_ms_i(ps), .rpl_q_o(rp_q), .rpl_elapsed_ms_o(rp_el));
   // ****
   // checks and waits
   // ****
   // wide enough for two flags beside an elapsed count
   task automatic cmp(input logic [`TIME_W+1:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // durations: ticks are shared, so first ms may be short
   task automatic span(input int got, lo, hi);
      n_compared++;
      if (got <= lo || got > hi) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, got, hi);
      end
   endtask
   function automatic logic pick(input int k);
      pick = (k == 0) ? f_q : (k == 1) ? n_q : p_q;
   endfunction
   task automatic wait_for(input int k, input logic v, output int n);
      n = 0;
      while (pick(k) !== v) begin
         @(negedge mclk_i);
         n++;
         if (n > 3 * MS) begin
            cmp(pick(k), v);
            summarize();
         end
      end
   endtask
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_latch;
      logic [2:0] st [8] = '{3'h5, 3'h4, 3'h7, 3'h5, 3'h6, 3'h5, 3'h1, 3'h4};
      logic r = 1'h0, s = 1'h0, rr = 1'h0, rs = 1'h0;
      for (int i = 0; i < 8; i++) begin
         {l_en, l_w, l_on} = st[i];
         r = l_en & ~l_w & (l_on | r);
         s = l_en & (l_on | (~l_w & s));
         rr = ~l_w & (l_on | rr);
         rs = l_on | (~l_w & rs);
         @(negedge mclk_i);
         cmp(rdl_q, r);
         cmp(sdl_q, s);
         cmp({rrd_q, rsd_q}, {rr, rs});
         cmp({rdl_eo, sdl_eo}, {l_en, l_en});
      end
   endtask
   task automatic t_off;
      int n;
      {f_en, f_tr} = 2'h3;
      repeat (2) @(negedge mclk_i);
      cmp({f_q, f_eo, f_el}, {2'h3, 32'h0});
      f_tr = 1'h0;
      // retrigger after one tick so an unabandoned delay would show
      repeat (MS + MS / 2) @(negedge mclk_i);
      cmp(f_el, 32'h1);
      f_tr = 1'h1;
      repeat (2) @(negedge mclk_i);
      cmp({f_q, f_el}, {1'h1, 32'h0});
      f_tr = 1'h0;
      wait_for(0, 1'h0, n);
      span(n, MS, 2 * MS + 3);
      cmp({rf_q, rf_el}, 33'h0);
   endtask
   task automatic t_on;
      int n;
      {n_en, n_tr} = 2'h3;
      // drop after one tick so kept partial timing would show
      repeat (MS + MS / 2) @(negedge mclk_i);
      cmp({n_q, n_el}, 33'h1);
      n_tr = 1'h0;
      repeat (2) @(negedge mclk_i);
      cmp({n_q, n_el}, 33'h0);
      n_tr = 1'h1;
      wait_for(1, 1'h1, n);
      span(n, MS, 2 * MS + 3);
      cmp({rn_q, n_el}, {1'h1, 32'h2});
      cmp(rn_el, 32'h1);
      n_en = 1'h0;
      repeat (2) @(negedge mclk_i);
      cmp({n_q, n_eo, n_el}, 34'h0);
   endtask
   task automatic t_pulse;
      int n;
      {p_en, p_tr} = 2'h3;
      repeat (2) @(negedge mclk_i);
      cmp(p_q, 1'h1);
      cmp(p_eo, 1'h1);
      p_tr = 1'h0;
      // retrigger after one tick so a restarted pulse would run long
      repeat (MS + MS / 2) @(negedge mclk_i);
      cmp(p_el, 32'h1);
      p_tr = 1'h1;
      cmp(p_q, 1'h1);
      wait_for(2, 1'h0, n);
      span(n + MS + MS / 2 + 2, MS, 2 * MS + 3);
      repeat (4) @(negedge mclk_i);
      cmp({rp_q, p_q}, 2'h0);
      cmp(p_el, 32'h0);
      cmp(rp_el, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge mclk_i);
      @(negedge mclk_i);
      rstn_i = 1'h1;
      lvl = 32'h1;
      repeat (2) @(negedge mclk_i);
      t_latch();
      fork
         t_off();
         t_on();
         t_pulse();
      join
      summarize();
   end
endmodule
